// ---- include/dds_cfg.svh ----
// Register map, field positions and fixed counts of the synthesizer.
// Assumes inclusion by bare name from the design files.
`ifndef DDS_CFG_SVH
`define DDS_CFG_SVH

// ==========================================================
// Register byte offsets
`define DDS_REG_SEL         8'h00
`define DDS_REG_DATA        8'h04
`define DDS_REG_STAT        8'h08

// ==========================================================
// Field positions
`define DDS_SEL_CHAN_MSB    3
`define DDS_SEL_OFF_BIT     8
`define DDS_STAT_CHAN_MSB   3
`define DDS_STAT_VALID_BIT  8
`define DDS_STAT_ACCEPT_BIT 9

// ==========================================================
// Reset values and counts
`define DDS_SEL_RESET       32'h0000_0000
`define DDS_MAX_CHANNELS    16
`define DDS_TBL_W           16
`define DDS_LUT_IDX_W       6
`define DDS_RD_WAIT_CYCLES  1

`endif

// ---- include/dds_pkg.sv ----
// Types shared by the synthesizer modules.
// Assumes nothing outside; compiled before the design modules.
package dds_pkg;

	// ==========================================================
	// Build-time modes
	typedef enum logic [1:0] {DDS_INC_FIXED, DDS_INC_PROG, DDS_INC_STREAM} dds_inc_mode_t;
	typedef enum logic [1:0] {DDS_OFF_NONE, DDS_OFF_FIXED, DDS_OFF_PROG, DDS_OFF_STREAM}
		dds_off_mode_t;
	typedef enum logic [1:0] {DDS_OUT_SINE, DDS_OUT_COSINE, DDS_OUT_BOTH} dds_out_sel_t;
	typedef enum logic {DDS_AMP_FULL, DDS_AMP_UNIT} dds_amp_t;
	typedef enum logic {DDS_PART_FULL, DDS_PART_PHASE_ONLY} dds_part_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [3:0] chan;
		logic       sel_off;
	} dds_prog_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       rd_wait;
		logic [7:0] addr;
	} dds_bus_t;

endpackage : dds_pkg

// ---- logic/dds_lut.sv ----
// Sine/cosine lookup with one registered stage, like a block memory.
// Assumes a phase index of six bits from the phase generator.
`timescale 1ns/1ps
`include "dds_cfg.svh"

module dds_lut import dds_pkg::*; #(
	parameter int           OUT_W      = 16,
	parameter dds_out_sel_t OUT_SEL    = DDS_OUT_BOTH,
	parameter bit           NEG_SINE   = 1'b0,
	parameter bit           NEG_COSINE = 1'b0,
	parameter dds_amp_t     AMP_MODE   = DDS_AMP_FULL
) (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic                      advance,
	input  wire logic [`DDS_LUT_IDX_W-1:0] phase_idx,
	output logic      [OUT_W-1:0]          sine_out,
	output logic      [OUT_W-1:0]          cosine_out
);

	// ==========================================================
	// Quarter wave, sampled at half steps so no entry is zero
	localparam logic [`DDS_TBL_W-1:0] QTBL [16] = '{
		16'h0648, 16'h12C8, 16'h1F1A, 16'h2B1F, 16'h36BA, 16'h41CD, 16'h4C3F, 16'h55F5,
		16'h5ED7, 16'h66CF, 16'h6DC9, 16'h73B5, 16'h7884, 16'h7C29, 16'h7E9C, 16'h7FD8};
	localparam int          SHIFT = `DDS_TBL_W - OUT_W + ((AMP_MODE == DDS_AMP_UNIT) ? 1 : 0);
	localparam logic [16:0] HALF  = (AMP_MODE == DDS_AMP_UNIT) ? (17'h1 << (SHIFT - 1)) : 17'h0;

	typedef struct packed {
		logic [OUT_W-1:0] sine;
		logic [OUT_W-1:0] cosine;
	} dds_lut_state_t;

	dds_lut_state_t st_reg;
	dds_lut_state_t st_next;

	function automatic logic [OUT_W-1:0] sample_of(input logic [1:0] quad,
			input logic [3:0] idx, input logic neg);
		logic [3:0]       i;
		logic [16:0]      rnd;
		logic [OUT_W-1:0] mag;
		i   = quad[0] ? ~idx : idx;
		// Unit circle halves the scale, rounding each entry to nearest
		rnd = {1'b0, QTBL[i]} + HALF;
		mag = OUT_W'(rnd >> SHIFT);
		// Crest entry pinned so unit circle peaks at exactly one half
		if (AMP_MODE == DDS_AMP_UNIT && i == 4'hF) begin
			mag = OUT_W'(1) << (OUT_W - 2);
		end
		sample_of = (quad[1] ^ neg) ? OUT_W'(-mag) : mag;
	endfunction : sample_of

	always_comb begin
		st_next = st_reg;
		if (advance) begin
			// Absent outputs are held at zero
			st_next.sine   = (OUT_SEL != DDS_OUT_COSINE) ?
				sample_of(phase_idx[5:4], phase_idx[3:0], NEG_SINE) : '0;
			st_next.cosine = (OUT_SEL != DDS_OUT_SINE) ?
				sample_of(phase_idx[5:4] + 2'h1, phase_idx[3:0], NEG_COSINE) : '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sine_out   = st_reg.sine;
	assign cosine_out = st_reg.cosine;

endmodule : dds_lut

// ---- logic/dds_top.sv ----
// Direct digital synthesizer: multi-channel phase accumulator, offset adder,
// sine/cosine lookup, and an AHB-Lite slave for run-time increment/offset.
// Assumes inputs synchronous to hclk and a single AHB-Lite master.
//
// Function
// - phase width sizes phase, accumulator, registers, data
// - output width sizes samples; absent if phase-only (here the sample ports stay and are tied to zero)
// - fixed increment is a build constant
// - programmable increment/offset written via channel, select, data
// - streamed increment taken from input each cycle
// - streamed offset taken directly from its input
// - no offset hardware when offset disabled
// - fixed offset is a build constant
// - quadrature or single sine/cosine output
// - independent sine and cosine negation
// - full range nearly fills two's complement
// - unit circle peaks at plus/minus one half
// - folded single-channel registers start at zero
// - streamed increment adds a latency cycle
// - phase output aligned with its samples
// - optional clock enable and synchronous clear
// - valid output marks valid samples
// - ready-for-data output always asserted
// - channel index output for current results
// - programmable registers start at build values
// - increment is unsigned fraction, zero-extended
// - upper half increments alias negative
// - negative offsets equal positive modulo cycle
// - one to sixteen time-multiplexed channels
// - correction option needs twelve-bit phase
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "dds_cfg.svh"

module dds_top import dds_pkg::*; #(
	parameter int                 PHASE_W    = 16,
	parameter int                 OUT_W      = 16,
	parameter int                 CHANNELS   = 1,
	parameter dds_part_t          PART       = DDS_PART_FULL,
	parameter dds_inc_mode_t      INC_MODE   = DDS_INC_PROG,
	parameter dds_off_mode_t      OFF_MODE   = DDS_OFF_PROG,
	parameter dds_out_sel_t       OUT_SEL    = DDS_OUT_BOTH,
	parameter bit                 NEG_SINE   = 1'b0,
	parameter bit                 NEG_COSINE = 1'b0,
	parameter dds_amp_t           AMP_MODE   = DDS_AMP_FULL,
	parameter bit                 HAS_CE     = 1'b1,
	parameter bit                 HAS_SYNC_CLEAR   = 1'b1,
	parameter bit                 FOLD_REGS  = 1'b0,
	parameter bit                 TAYLOR_EN  = 1'b0,
	parameter logic [15:0][31:0]  INC_INIT   = '0,
	parameter logic [15:0][31:0]  OFF_INIT   = '0
) (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic               ce,
	input  wire logic               sync_clear,
	input  wire logic [PHASE_W-1:0] increment_stream_in,
	input  wire logic [PHASE_W-1:0] offset_stream_in,
	output logic      [PHASE_W-1:0] phase_out,
	output logic      [OUT_W-1:0]   sine_out,
	output logic      [OUT_W-1:0]   cosine_out,
	output logic                    sample_valid,
	output logic                    input_accept,
	output logic      [3:0]         chan_out
);

	// ==========================================================
	// Build checks
	if (PHASE_W < 6 || PHASE_W > 32) $error("phase width must lie in 6..32");
	if (OUT_W < 3 || OUT_W > `DDS_TBL_W) $error("output width must lie in 3..16");
	if (CHANNELS < 1 || CHANNELS > `DDS_MAX_CHANNELS) $error("channels must lie in 1..16");
	if (TAYLOR_EN && PHASE_W < 12) $error("correction needs phase width of 12 or more");

	// Folding only applies to one channel with nothing streamed
	localparam bit FOLD = FOLD_REGS && CHANNELS == 1 && INC_MODE != DDS_INC_STREAM &&
		OFF_MODE != DDS_OFF_STREAM;

	typedef struct packed {
		logic [CHANNELS-1:0][PHASE_W-1:0] inc;
		logic [CHANNELS-1:0][PHASE_W-1:0] off;
		logic [CHANNELS-1:0][PHASE_W-1:0] acc;
		logic [PHASE_W-1:0]               inc_strm;
		logic [3:0]                       ch;
		logic [3:0]                       ch1;
		logic [3:0]                       ch2;
		logic [PHASE_W-1:0]               phase1;
		logic [PHASE_W-1:0]               phase2;
		logic                             v1;
		logic                             v2;
		dds_prog_t                        prog;
		dds_bus_t                         bus;
		logic [31:0]                      rdata;
	} dds_state_t;

	// ==========================================================
	// Helpers
	function automatic logic [PHASE_W-1:0] init_inc(input int c);
		init_inc = (FOLD && INC_MODE == DDS_INC_PROG) ? '0 : INC_INIT[c][PHASE_W-1:0];
	endfunction : init_inc

	function automatic logic [PHASE_W-1:0] init_off(input int c);
		init_off = (FOLD && OFF_MODE == DDS_OFF_PROG) ? '0 : OFF_INIT[c][PHASE_W-1:0];
	endfunction : init_off

	function automatic logic [3:0] chan_next(input logic [3:0] c);
		chan_next = (c == 4'(CHANNELS - 1)) ? 4'h0 : c + 4'h1;
	endfunction : chan_next

	function automatic dds_state_t reset_state();
		dds_state_t s;
		s = '0;
		for (int c = 0; c < CHANNELS; c++) begin
			s.inc[c] = init_inc(c);
			// Unused offset flops stay constant and are pruned
			s.off[c] = (OFF_MODE == DDS_OFF_PROG) ? init_off(c) : '0;
		end
		reset_state = s;
	endfunction : reset_state

	localparam dds_state_t ST_RST = reset_state();

	dds_state_t         st_reg;
	dds_state_t         st_next;
	logic               ce_eff;
	logic               clr_eff;
	logic               take;
	logic               sel_ok;
	logic [PHASE_W-1:0] inc_now;
	logic [PHASE_W-1:0] off_now;
	logic [PHASE_W-1:0] sel_val;
	logic [31:0]        rd_val;

	assign ce_eff  = HAS_CE ? ce : 1'b1;
	assign clr_eff = HAS_SYNC_CLEAR ? sync_clear : 1'b0;
	assign take    = hsel && htrans[1] && hready;
	assign sel_ok  = {1'b0, st_reg.prog.chan} < 5'(CHANNELS);

	// ==========================================================
	// Per-channel operands
	always_comb begin
		case (INC_MODE)
			DDS_INC_STREAM: inc_now = st_reg.inc_strm;
			DDS_INC_PROG:   inc_now = st_reg.inc[st_reg.ch];
			default:        inc_now = init_inc(int'(st_reg.ch));
		endcase
		case (OFF_MODE)
			DDS_OFF_STREAM: off_now = offset_stream_in;
			DDS_OFF_PROG:   off_now = st_reg.off[st_reg.ch];
			DDS_OFF_FIXED:  off_now = init_off(int'(st_reg.ch));
			default:        off_now = '0;
		endcase
		if (!sel_ok) begin
			sel_val = '0;
		end else if (st_reg.prog.sel_off) begin
			sel_val = (OFF_MODE == DDS_OFF_PROG) ? st_reg.off[st_reg.prog.chan] : '0;
		end else if (INC_MODE == DDS_INC_PROG) begin
			sel_val = st_reg.inc[st_reg.prog.chan];
		end else begin
			sel_val = '0;
		end
	end

	// ==========================================================
	// Register read decode
	always_comb begin
		rd_val = 32'h0000_0000;
		if (st_reg.bus.addr == `DDS_REG_SEL) begin
			rd_val[`DDS_SEL_CHAN_MSB:0] = st_reg.prog.chan;
			rd_val[`DDS_SEL_OFF_BIT]    = st_reg.prog.sel_off;
		end else if (st_reg.bus.addr == `DDS_REG_DATA) begin
			rd_val[PHASE_W-1:0] = sel_val;
		end else if (st_reg.bus.addr == `DDS_REG_STAT) begin
			rd_val[`DDS_STAT_CHAN_MSB:0]  = st_reg.ch2;
			rd_val[`DDS_STAT_VALID_BIT]   = st_reg.v2;
			rd_val[`DDS_STAT_ACCEPT_BIT]  = 1'b1;
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		// Bus data phases
		if (st_reg.bus.rd && !st_reg.bus.rd_wait) begin
			// Wait state lets a preceding write land before the read is sampled
			st_next.rdata       = rd_val;
			st_next.bus.rd_wait = 1'b1;
		end else if (st_reg.bus.rd) begin
			st_next.bus.rd      = 1'b0;
			st_next.bus.rd_wait = 1'b0;
		end
		if (st_reg.bus.wr) begin
			st_next.bus.wr = 1'b0;
			if (st_reg.bus.addr == `DDS_REG_SEL) begin
				st_next.prog.chan    = hwdata[`DDS_SEL_CHAN_MSB:0];
				st_next.prog.sel_off = hwdata[`DDS_SEL_OFF_BIT];
			end else if (st_reg.bus.addr == `DDS_REG_DATA && sel_ok) begin
				// Other modes ignore the write; narrower fields zero-extend
				if (st_reg.prog.sel_off && OFF_MODE == DDS_OFF_PROG) begin
					st_next.off[st_reg.prog.chan] = hwdata[PHASE_W-1:0];
				end else if (!st_reg.prog.sel_off && INC_MODE == DDS_INC_PROG) begin
					st_next.inc[st_reg.prog.chan] = hwdata[PHASE_W-1:0];
				end
			end
		end
		if (take) begin
			st_next.bus.wr      = hwrite;
			st_next.bus.rd      = !hwrite;
			st_next.bus.rd_wait = 1'b0;
			st_next.bus.addr    = haddr[7:0];
		end
		// Datapath; enable low holds every stage
		if (ce_eff) begin
			st_next.inc_strm = increment_stream_in;
			if (clr_eff) begin
				st_next.acc = '0;
				st_next.ch  = 4'h0;
				st_next.ch1 = 4'h0;
				st_next.ch2 = 4'h0;
				st_next.v1  = 1'b0;
				st_next.v2  = 1'b0;
			end else begin
				// Wraps modulo one cycle, so upper-half increments run backwards
				st_next.acc[st_reg.ch] = st_reg.acc[st_reg.ch] + inc_now;
				st_next.phase1 = (OFF_MODE == DDS_OFF_NONE) ? st_reg.acc[st_reg.ch] :
					st_reg.acc[st_reg.ch] + off_now;
				st_next.ch1    = st_reg.ch;
				st_next.v1     = 1'b1;
				st_next.phase2 = st_reg.phase1;
				st_next.ch2    = st_reg.ch1;
				st_next.v2     = st_reg.v1;
				st_next.ch     = chan_next(st_reg.ch);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Lookup and outputs
	if (PART == DDS_PART_FULL) begin : g_lut
		dds_lut #(
			.OUT_W      (OUT_W),
			.OUT_SEL    (OUT_SEL),
			.NEG_SINE   (NEG_SINE),
			.NEG_COSINE (NEG_COSINE),
			.AMP_MODE   (AMP_MODE)
		) u_lut (
			.hclk       (hclk),
			.hresetn    (hresetn),
			.advance    (ce_eff),
			.phase_idx  (st_reg.phase1[PHASE_W-1 -: `DDS_LUT_IDX_W]),
			.sine_out   (sine_out),
			.cosine_out (cosine_out)
		);
	end else begin : g_no_lut
		assign sine_out   = '0;
		assign cosine_out = '0;
	end

	assign phase_out    = st_reg.phase2;
	assign sample_valid = st_reg.v2;
	assign chan_out     = st_reg.ch2;
	assign input_accept = 1'b1;
	assign hreadyout    = !(st_reg.bus.rd && !st_reg.bus.rd_wait);
	assign hresp        = 1'b0;
	assign hrdata       = st_reg.rdata;

	// ==========================================================
	// Checks
	accept_always_a: assert property (@(posedge hclk) disable iff (!hresetn)
		input_accept && !hresp) else $error("accept or response wrong");

	clear_valid_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce_eff && clr_eff) |=> (!sample_valid && chan_out == 4'h0 ##1 !sample_valid))
		else $error("clear did not drop valid for two cycles");

	freeze_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!ce_eff |=> ($stable(phase_out) && $stable(chan_out) && $stable(sine_out) &&
		$stable(sample_valid))) else $error("outputs moved while disabled");

	chan_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce_eff && !clr_eff && sample_valid) |=> (chan_out == chan_next($past(chan_out))))
		else $error("channel index did not advance");

	valid_fill_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(hresetn && ce_eff && !clr_eff ##1 ce_eff && !clr_eff) |=> sample_valid)
		else $error("valid missing two enabled cycles after start");

	if (PART == DDS_PART_FULL && OUT_SEL != DDS_OUT_COSINE) begin : g_chk_sine
		sine_sign_a: assert property (@(posedge hclk) disable iff (!hresetn)
			sample_valid |-> (sine_out[OUT_W-1] == (phase_out[PHASE_W-1] ^ NEG_SINE)))
			else $error("sine sign not tied to its phase");
	end

	if (PART == DDS_PART_FULL && AMP_MODE == DDS_AMP_UNIT) begin : g_chk_unit
		unit_peak_a: assert property (@(posedge hclk) disable iff (!hresetn)
			sample_valid |-> ($signed(sine_out) <= $signed(OUT_W'(1) <<< (OUT_W - 2)) &&
			$signed(sine_out) >= -$signed(OUT_W'(1) <<< (OUT_W - 2))))
			else $error("unit circle sample beyond one half");
	end

	if (CHANNELS == 1 && INC_MODE == DDS_INC_FIXED &&
		(OFF_MODE == DDS_OFF_NONE || OFF_MODE == DDS_OFF_FIXED))
	begin : g_chk_step
		phase_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
			(ce_eff && !clr_eff && sample_valid && !st_reg.bus.wr) |=>
			(phase_out == $past(phase_out) + init_inc(0)))
			else $error("phase did not advance by the increment");
	end

	read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && !hwrite) |=> (!hreadyout ##1 hreadyout))
		else $error("read did not take exactly one wait state");

endmodule : dds_top

// ---- bench/dds_sink.sv ----
// Downstream consumer model: records every valid result it is handed.
// Assumes it samples the synthesizer outputs on the synthesizer clock.
`timescale 1ns/1ps

module dds_sink (
	input  wire logic        hclk,
	input  wire logic        ce,
	input  wire logic        sample_valid,
	input  wire logic [3:0]  chan_out,
	input  wire logic [15:0] phase_out,
	input  wire logic [15:0] sine_out,
	input  wire logic [15:0] cosine_out,
	input  wire logic        input_accept
);
	// ====================
	// Capture
	logic [51:0] got[$];

	// Never waits on input_accept: the device always takes data
	always @(posedge hclk) begin
		if (ce && sample_valid)
			got.push_back({chan_out, phase_out, sine_out, cosine_out});
	end
endmodule : dds_sink

// ---- bench/direct_digital_synthesizer_test.sv ----
// Self-checking bench for the synthesizer: bus access, run, clear, freeze.
// Assumes the register map header and a two-channel programmable build.
`timescale 1ns/1ps
`include "dds_cfg.svh"

module direct_digital_synthesizer_test;
	// ====================
	// Signals
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        ce = 1'b1;
	logic        sync_clear = 1'b0;
	logic [15:0] phase_out;
	logic [15:0] sine_out;
	logic [15:0] cosine_out;
	logic        sample_valid;
	logic        input_accept;
	logic [3:0]  chan_out;
	logic [15:0] inc[2];
	logic [15:0] off[2];
	int          n_fail = 0;
	int          checks = 0;

	always #10 hclk = ~hclk;

	dds_top #(
		.CHANNELS (2),
		.INC_INIT ({448'h0, 32'h0000_0123, 32'h0})
	) i_dut (
		.hclk                (hclk),
		.hresetn             (hresetn),
		.hsel                (hsel),
		.haddr               (haddr),
		.htrans              (htrans),
		.hwrite              (hwrite),
		.hsize               (hsize),
		.hwdata              (hwdata),
		.hready              (hreadyout),
		.hrdata              (hrdata),
		.hreadyout           (hreadyout),
		.hresp               (hresp),
		.ce                  (ce),
		.sync_clear          (sync_clear),
		.increment_stream_in (16'h0),
		.offset_stream_in    (16'h0),
		.phase_out           (phase_out),
		.sine_out            (sine_out),
		.cosine_out          (cosine_out),
		.sample_valid        (sample_valid),
		.input_accept        (input_accept),
		.chan_out            (chan_out)
	);

	dds_sink i_sink (
		.hclk         (hclk),
		.ce           (ce),
		.sample_valid (sample_valid),
		.chan_out     (chan_out),
		.phase_out    (phase_out),
		.sine_out     (sine_out),
		.cosine_out   (cosine_out),
		.input_accept (input_accept)
	);

	// ====================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	// Ready and data taken at the edge, before the design updates; watchdog ends a hang
	task automatic wait_ready(output logic [31:0] d);
		do begin
			@(posedge hclk);
		end while (hreadyout !== 1'b1);
		d = hrdata;
	endtask : wait_ready

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		logic [31:0] x;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_ready(x);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready(rd);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		check(what, x, exp);
	endtask : rd_chk

	// ====================
	// Scenarios
	task automatic reset_check();
		#1 check("hreadyout", hreadyout, 1'b1);
		check("hresp", hresp, 1'b0);
		check("accept", input_accept, 1'b1);
		check("valid", sample_valid, 1'b0);
		check("phase", phase_out, 16'h0);
	endtask : reset_check

	task automatic map_check();
		logic [31:0] x;
		bus(1'b0, `DDS_REG_STAT, 32'h0, x);
		check("stat accept", x[9], 1'b1);
		check("stat upper", x[31:10], 22'h0);
		rd_chk("unmapped", 8'h0C, 32'h0);
		wr(`DDS_REG_SEL, 32'h1);
		rd_chk("ch1 inc init", `DDS_REG_DATA, 32'h123);
		wr(`DDS_REG_SEL, 32'h101);
		rd_chk("ch1 off init", `DDS_REG_DATA, 32'h0);
		wr(`DDS_REG_SEL, 32'h2);
		wr(`DDS_REG_DATA, 32'h5);
		rd_chk("absent chan", `DDS_REG_DATA, 32'h0);
	endtask : map_check

	// Loads inc/off into both channels and reads each back
	task automatic load();
		logic [15:0] v;
		for (int c = 0; c < 4; c++) begin
			v = (c < 2) ? inc[c % 2] : off[c % 2];
			wr(`DDS_REG_SEL, {23'h0, c[1], 7'h0, c[0]});
			wr(`DDS_REG_DATA, {16'hFFFF, v});
			rd_chk("readback", `DDS_REG_DATA, {16'h0, v});
		end
	endtask : load

	// Clear, then compare eight results against the accumulated phase
	task automatic run_check();
		logic [51:0] s;
		logic [15:0] ph;
		sync_clear <= 1'b1;
		@(posedge hclk);
		sync_clear <= 1'b0;
		@(posedge hclk);
		#1 check("valid after clear", sample_valid, 1'b0);
		// Emptied once no stale result can still be pushed
		i_sink.got.delete();
		@(posedge hclk);
		#1 check("valid second edge", sample_valid, 1'b1);
		repeat (10) @(posedge hclk);
		for (int i = 0; i < 8; i++) begin
			s = i_sink.got[i];
			ph = 16'(inc[i % 2] * (i / 2)) + off[i % 2];
			check("channel", s[51:48], 4'(i % 2));
			check("phase", s[47:32], ph);
			check("sine sign", s[31], ph[15]);
			check("cosine sign", s[15], ph[15] ^ ph[14]);
		end
	endtask : run_check

	task automatic freeze_check();
		logic [15:0] ph;
		int          n;
		ce <= 1'b0;
		sync_clear <= 1'b1;
		@(posedge hclk);
		#1 ph = phase_out;
		n = i_sink.got.size();
		repeat (6) @(posedge hclk);
		#1 check("frozen phase", phase_out, ph);
		check("frozen valid", sample_valid, 1'b1);
		check("no new samples", i_sink.got.size(), n);
		@(posedge hclk);
		ce <= 1'b1;
		sync_clear <= 1'b0;
	endtask : freeze_check

	// ====================
	// Sequence
	initial begin
		repeat (20) @(posedge hclk);
		reset_check();
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		map_check();
		inc = '{16'h0400, 16'hC000};
		off = '{16'h0000, 16'h0000};
		load();
		run_check();
		inc = '{16'h1234, 16'hFFFF};
		off = '{16'hF000, 16'h8000};
		load();
		run_check();
		freeze_check();
		complete_run();
	end

	initial begin
		#50us;
		n_fail++;
		complete_run();
	end
endmodule : direct_digital_synthesizer_test
